// ===== verilog/lpc_led_stage.sv
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module lpc_led_stage
  import lpc_pkg::*;
#(
  parameter int NUM_CH       = 4,
  parameter int DIM_SLOT     = DIM_SLOT_CYC,
  parameter int BLINK_SLOT   = BLINK_SLOT_CYC
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire logic [3:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  output logic      [NUM_CH-1:0]  channel_output_pin_o,
  output logic      [NUM_CH-1:0]  channel_output_pin_oe
);

  //----------------------------------------------------------------
  // Elaboration checks
  //----------------------------------------------------------------
  if (NUM_CH != 4) begin : g_bad_ch
    $error("lpc_led_stage: NUM_CH must be 4");
  end
  if (DIM_SLOT < 1 || DIM_SLOT > 65535) begin : g_bad_dim
    $error("lpc_led_stage: DIM_SLOT out of range");
  end
  if (BLINK_SLOT < 1 || BLINK_SLOT > 65535) begin : g_bad_blink
    $error("lpc_led_stage: BLINK_SLOT out of range");
  end

  localparam logic [15:0] PWM_LAST   = 16'(PWM_SLOT_CYC - 1);
  localparam logic [15:0] DIM_LAST   = 16'(DIM_SLOT - 1);
  localparam logic [15:0] BLINK_LAST = 16'(BLINK_SLOT - 1);

  // Group duty as compared against the group phase, per mode
  function automatic logic [7:0] grp_duty_eff(
    input logic [7:0] duty,
    input logic       blink,
    input logic [7:0] period
  );
    if (!blink) begin
      grp_duty_eff = {duty[7:4], 4'h0};
    end else if (period <= BLINK_FAST_MAX) begin
      grp_duty_eff = {duty[7:2], 2'h0};
    end else begin
      grp_duty_eff = duty;
    end
  endfunction

  //----------------------------------------------------------------
  // Register file
  //----------------------------------------------------------------
  lpc_mode_s         mode, next_mode;
  logic [7:0]        channel_state_register, next_state_reg;
  logic [7:0]        channel_duty_value [NUM_CH];
  logic [7:0]        next_duty [NUM_CH];
  logic [7:0]        group_duty_value, next_gduty;
  logic [7:0]        group_period_value, next_gperiod;
  logic [7:0]        next_rdata;
  logic [NUM_CH-1:0] lower_on;
  logic              grp_sig;

  always_comb begin
    next_mode      = mode;
    next_state_reg = channel_state_register;
    next_gduty     = group_duty_value;
    next_gperiod   = group_period_value;
    for (int i = 0; i < NUM_CH; i++) begin
      next_duty[i] = channel_duty_value[i];
    end
    next_rdata = RST_VAL;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_MODE: begin
          next_mode.output_invert       = reg_wdata[BIT_INVERT];
          next_mode.output_drive_type   = reg_wdata[BIT_DRIVE];
          next_mode.dim_or_blink_select = reg_wdata[BIT_DMBL];
        end
        ADDR_STATE:   next_state_reg = reg_wdata;
        ADDR_GDUTY:   next_gduty     = reg_wdata;
        ADDR_GPERIOD: next_gperiod   = reg_wdata;
        default: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (reg_addr == ADDR_DUTY0 + 4'(i)) begin
              next_duty[i] = reg_wdata;
            end
          end
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_MODE:    next_rdata = {5'h00, mode};
        ADDR_STATE:   next_rdata = channel_state_register;
        ADDR_GDUTY:   next_rdata = group_duty_value;
        ADDR_GPERIOD: next_rdata = group_period_value;
        ADDR_STATUS:  next_rdata = {3'h0, grp_sig, lower_on};
        default: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (reg_addr == ADDR_DUTY0 + 4'(i)) begin
              next_rdata = channel_duty_value[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode                   <= '0;
      channel_state_register <= RST_VAL;
      group_duty_value       <= RST_VAL;
      group_period_value     <= RST_VAL;
      reg_rdata              <= RST_VAL;
      for (int i = 0; i < NUM_CH; i++) begin
        channel_duty_value[i] <= RST_VAL;
      end
    end else begin
      mode                   <= next_mode;
      channel_state_register <= next_state_reg;
      group_duty_value       <= next_gduty;
      group_period_value     <= next_gperiod;
      reg_rdata              <= next_rdata;
      for (int i = 0; i < NUM_CH; i++) begin
        channel_duty_value[i] <= next_duty[i];
      end
    end
  end

  //----------------------------------------------------------------
  // Free-running timebases
  //----------------------------------------------------------------
  logic [15:0] pwm_pre, next_pwm_pre;
  logic [7:0]  pwm_phase, next_pwm_phase;
  logic [15:0] dim_pre, next_dim_pre;
  logic [7:0]  dim_phase, next_dim_phase;
  logic [15:0] blk_pre, next_blk_pre;
  logic [7:0]  blk_units, next_blk_units;
  logic [7:0]  blk_phase, next_blk_phase;
  logic        pwm_tick;
  logic        dim_tick;
  logic        blk_tick;
  logic        blk_step;

  // Blink slot is a whole number of 1/6144 s units, so a period change
  // takes effect at the next unit tick rather than restarting the pattern.
  always_comb begin
    pwm_tick       = (pwm_pre == PWM_LAST);
    dim_tick       = (dim_pre == DIM_LAST);
    blk_tick       = (blk_pre == BLINK_LAST);
    blk_step       = blk_tick && (blk_units >= group_period_value);
    next_pwm_pre   = pwm_tick ? '0 : pwm_pre + 16'h0001;
    next_pwm_phase = pwm_tick ? pwm_phase + 8'h01 : pwm_phase;
    next_dim_pre   = dim_tick ? '0 : dim_pre + 16'h0001;
    next_dim_phase = dim_tick ? dim_phase + 8'h01 : dim_phase;
    next_blk_pre   = blk_tick ? '0 : blk_pre + 16'h0001;
    next_blk_units = blk_step ? '0 :
                     (blk_tick ? blk_units + 8'h01 : blk_units);
    next_blk_phase = blk_step ? blk_phase + 8'h01 : blk_phase;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_pre   <= '0;
      pwm_phase <= '0;
      dim_pre   <= '0;
      dim_phase <= '0;
      blk_pre   <= '0;
      blk_units <= '0;
      blk_phase <= '0;
    end else begin
      pwm_pre   <= next_pwm_pre;
      pwm_phase <= next_pwm_phase;
      dim_pre   <= next_dim_pre;
      dim_phase <= next_dim_phase;
      blk_pre   <= next_blk_pre;
      blk_units <= next_blk_units;
      blk_phase <= next_blk_phase;
    end
  end

  //----------------------------------------------------------------
  // Group signal and output stage
  //----------------------------------------------------------------
  logic [7:0]        grp_eff;
  logic [NUM_CH-1:0] ind_pwm;
  logic [NUM_CH-1:0] active;
  lpc_pins_s         pins, next_pins;

  always_comb begin
    grp_eff = grp_duty_eff(group_duty_value, mode.dim_or_blink_select,
                           group_period_value);
    grp_sig = mode.dim_or_blink_select ? (blk_phase < grp_eff)
                                       : (dim_phase < grp_eff);
  end

  // Per-channel locals keep each shared vector bit to a single driver
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [1:0] fld;
    logic       ind;
    logic       act;
    logic       low;
    assign fld = channel_state_register[2*c +: 2];
    assign ind = pwm_phase < channel_duty_value[c];
    always_comb begin
      case (fld)
        ST_OFF:   act = 1'b0;
        ST_ON:    act = 1'b1;
        ST_PWM:   act = ind;
        ST_GROUP: act = ind & grp_sig;
        default:  act = 1'b0;
      endcase
    end
    // Inverting flips the sink so the active level is 1 - duty
    assign low         = act ^ mode.output_invert;
    assign ind_pwm[c]  = ind;
    assign active[c]   = act;
    assign lower_on[c] = low;
    // Open drain floats when off; push-pull sources instead
    assign next_pins.out[c] = ~low;
    assign next_pins.oe[c]  = low | mode.output_drive_type;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pins <= '0;
    end else begin
      pins <= next_pins;
    end
  end

  assign channel_output_pin_o  = pins.out;
  assign channel_output_pin_oe = pins.oe;

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_pwm_wrap;
    pwm_tick && pwm_phase == 8'hFF;
  endsequence
  sequence s_phase_zero;
    pwm_phase == 8'h00;
  endsequence

  a_off_float: assert property (
    channel_state_register[1:0] == ST_OFF && mode == '0
    |=> !channel_output_pin_oe[0])
    else $error("off channel not floating");
  a_on_sink: assert property (
    channel_state_register[3:2] == ST_ON && !mode.output_invert
    |=> channel_output_pin_oe[1] && !channel_output_pin_o[1])
    else $error("on channel not sinking");
  a_pwm_follow: assert property (
    channel_state_register[5:4] == ST_PWM && !mode.output_invert
    |=> channel_output_pin_o[2] != $past(ind_pwm[2]))
    else $error("pwm channel lower transistor mismatch");
  a_group_od: assert property (
    channel_state_register[7:6] == ST_GROUP && !mode.output_drive_type
    |=> !(channel_output_pin_oe[3] && channel_output_pin_o[3]))
    else $error("open drain channel sourcing");
  a_group_pp: assert property (
    channel_state_register[1:0] == ST_GROUP && mode.output_drive_type
    |=> channel_output_pin_oe[0] &&
        channel_output_pin_o[0] == !$past(lower_on[0]))
    else $error("push-pull channel not driven");
  a_invert_on: assert property (
    channel_state_register[3:2] == ST_ON && mode.output_invert &&
    mode.output_drive_type
    |=> channel_output_pin_oe[1] && channel_output_pin_o[1])
    else $error("inverted on channel not high");
  a_pwm_wrap: assert property (
    s_pwm_wrap |=> s_phase_zero [*2])
    else $error("channel pwm phase wrap wrong");
  a_dim_step: assert property (
    dim_tick |=> dim_phase == $past(dim_phase) + 8'h01 && dim_pre == '0)
    else $error("dim phase step wrong");
  a_blink_step: assert property (
    blk_tick && blk_units >= group_period_value
    |=> blk_units == '0 && blk_phase == $past(blk_phase) + 8'h01)
    else $error("blink slot step wrong");
  a_group_shared: assert property (
    channel_state_register == 8'hFF
    |-> active == ({NUM_CH{grp_sig}} & ind_pwm))
    else $error("group signal not shared");
  a_state_write: assert property (
    reg_wr && reg_addr == ADDR_STATE
    |=> channel_state_register == $past(reg_wdata))
    else $error("state register write lost");
  a_dim_select: assert property (
    !mode.dim_or_blink_select &&
    dim_phase >= {group_duty_value[7:4], 4'h0}
    |-> !grp_sig)
    else $error("dimming group signal wrong");
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == RST_VAL)
    else $error("read data not cleared");
  a_pwm_bound: assert property (
    pwm_pre <= PWM_LAST)
    else $error("channel prescaler overran");

endmodule // lpc_led_stage

// ===== include/lpc_pkg.sv
//------------------------------------------------------------------
//------------------------------------------------------------------
package lpc_pkg;

  localparam int          CLK_HZ        = 200_000_000;
  // Channel PWM: 1.5625 kHz over 256 slots
  localparam int          PWM_FREQ_MHZ  = 1_562_500;  // millihertz
  localparam int          PWM_STEPS     = 256;
  localparam int          PWM_SLOT_CYC  =
    int'((64'(CLK_HZ) * 1000) / (64'(PWM_FREQ_MHZ) * PWM_STEPS));
  // Group dimming: 190 Hz over 256 slots
  localparam int          DIM_FREQ_HZ   = 190;
  localparam int          DIM_SLOT_CYC  = CLK_HZ / (DIM_FREQ_HZ * 256);
  // Blinking: period (value + 1) / 24 s, 256 slots each
  localparam int          BLINK_DIV     = 24;
  localparam int          BLINK_SLOT_CYC = CLK_HZ / (BLINK_DIV * 256);
  // Periods up to this value blink at 6 Hz or faster
  localparam logic [7:0]  BLINK_FAST_MAX = 8'h03;

  // Register offsets
  localparam logic [3:0]  ADDR_MODE     = 4'h0;
  localparam logic [3:0]  ADDR_STATE    = 4'h1;
  localparam logic [3:0]  ADDR_DUTY0    = 4'h2;
  localparam logic [3:0]  ADDR_GDUTY    = 4'h6;
  localparam logic [3:0]  ADDR_GPERIOD  = 4'h7;
  localparam logic [3:0]  ADDR_STATUS   = 4'h8;
  // Mode register bits
  localparam int          BIT_INVERT    = 0;
  localparam int          BIT_DRIVE     = 1;
  localparam int          BIT_DMBL      = 2;
  localparam logic [7:0]  RST_VAL       = 8'h00;

  localparam logic [1:0]  ST_OFF        = 2'b00;
  localparam logic [1:0]  ST_ON         = 2'b01;
  localparam logic [1:0]  ST_PWM        = 2'b10;
  localparam logic [1:0]  ST_GROUP      = 2'b11;

  typedef struct packed {
    logic dim_or_blink_select;
    logic output_drive_type;
    logic output_invert;
  } lpc_mode_s;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } lpc_pins_s;

endpackage

// ===== verif/lpc_led_load.sv
`timescale 1ns/10ps
module lpc_led_load (
  input  wire logic [3:0] pin_o,
  input  wire logic [3:0] pin_oe,
  output logic      [3:0] pin_level,
  output logic      [3:0] led_lit
);
  // Pull-up through the LED resistor: a released pin sits high
  assign pin_level = ~pin_oe | pin_o;
  // LED hangs from the supply, so it lights only while the pin sinks
  assign led_lit = ~pin_level;
endmodule // lpc_led_load

// ===== verif/tb.sv
`timescale 1ns/10ps
module tb;
  import lpc_pkg::*;
  localparam int SLOT = 4;
  localparam int CH_SLOT = 500;
  logic       sys_clk   = 1'b0;
  logic       rst_b     = 1'b0;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] pin_o;
  logic [3:0] pin_oe;
  logic [3:0] pin_level;
  logic [3:0] led_lit;
  logic [7:0] duty [4];
  int         miscompares = 0;
  int         num_checks  = 0;
  int         cyc         = 0;

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  lpc_led_stage #(.NUM_CH(4), .DIM_SLOT(SLOT), .BLINK_SLOT(SLOT)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .channel_output_pin_o(pin_o),
    .channel_output_pin_oe(pin_oe));
  lpc_led_load LOAD (.pin_o(pin_o), .pin_oe(pin_oe),
    .pin_level(pin_level), .led_lit(led_lit));

  //--------------------------------------------------------------
  // Reporting and bus tasks
  //--------------------------------------------------------------
  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    report({24'h0, got}, {24'h0, exp});
  endtask
  task automatic cmp_count(input int got, input int exp);
    report(32'(got), 32'(exp));
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Idle cycle after each strobe keeps every signal to one change per edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 cmp_byte(reg_rdata, exp);
    @(posedge sys_clk);
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
  endtask

  //--------------------------------------------------------------
  // Expected values
  //--------------------------------------------------------------
  function automatic logic [7:0] exp_pins(input logic [3:0] act,
                                          input logic [2:0] m);
    logic [3:0] lo;
    lo = act ^ {4{m[BIT_INVERT]}};
    return {lo | {4{m[BIT_DRIVE]}}, ~lo};
  endfunction
  function automatic int exp_grp(input logic [2:0] m, input logic [7:0] gd,
                                 input logic [7:0] gp);
    logic [7:0] e;
    e = !m[BIT_DMBL] ? gd & 8'hF0 : (gp <= BLINK_FAST_MAX ? gd & 8'hFC : gd);
    return int'(e) * SLOT * (m[BIT_DMBL] ? int'(gp) + 1 : 1);
  endfunction

  //--------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------
  task automatic run_static();
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MODE, (8'($urandom) & 8'hF8) | 8'(m));
      rd(ADDR_MODE, 8'(m));
      for (int s = 0; s < 2; s++) begin
        wr(ADDR_STATE, s ? 8'h55 : 8'h00);
        @(posedge sys_clk);
        #1 cmp_byte({pin_oe, pin_o}, exp_pins(s ? 4'hF : 4'h0, 3'(m)));
        @(posedge sys_clk);
      end
    end
  endtask
  // Counters restart at reset, so each pulse falls at duty times slot
  task automatic run_pwm(input logic [2:0] m);
    int fall [4];
    int bad;
    int t0;
    int e;
    bad = 0;
    do_reset();
    t0 = cyc;
    duty[0] = 8'h01;
    duty[1] = 8'h00;
    duty[2] = 8'(2 + $urandom_range(22));
    duty[3] = 8'(2 + $urandom_range(22));
    for (int c = 0; c < 4; c++) begin
      fall[c] = -1;
      wr(ADDR_DUTY0 + 4'(c), duty[c]);
    end
    wr(ADDR_MODE, 8'(m));
    wr(ADDR_STATE, 8'hAA);
    repeat (25 * CH_SLOT) begin
      @(posedge sys_clk);
      #1;
      for (int c = 0; c < 4; c++)
        if (fall[c] < 0 && !(led_lit[c] ^ m[BIT_INVERT])) fall[c] = cyc - t0;
      if (m[BIT_DRIVE] && pin_oe !== 4'hF) bad++;
    end
    for (int c = 0; c < 4; c++) begin
      e = int'(duty[c]) * CH_SLOT;
      cmp_count((fall[c] >= e - 4 && fall[c] <= e + 24) ? e : fall[c], e);
    end
    cmp_count(bad, 0);
    @(posedge sys_clk);
  endtask
  // A window of one whole group period gives an exact on-count
  task automatic run_grp(input logic [2:0] m, input logic [7:0] gd,
                         input logic [7:0] gp);
    int cnt [4];
    int bad;
    int win;
    win = 256 * SLOT * (m[BIT_DMBL] ? int'(gp) + 1 : 1);
    bad = 0;
    cnt = '{default: 0};
    wr(ADDR_GDUTY, gd);
    wr(ADDR_GPERIOD, gp);
    wr(ADDR_MODE, 8'(m));
    repeat (win) @(posedge sys_clk);
    repeat (win) begin
      @(posedge sys_clk);
      #1;
      for (int c = 0; c < 4; c++) cnt[c] += int'(led_lit[c] ^ m[BIT_INVERT]);
      if (m[BIT_DRIVE] && pin_oe !== 4'hF) bad++;
    end
    for (int c = 0; c < 4; c++)
      cmp_count(cnt[c], exp_grp(m, gd, gp));
    cmp_count(bad, 0);
    @(posedge sys_clk);
  endtask

  initial begin
    void'($urandom(33042));
    do_reset();
    #1 cmp_byte({pin_oe, pin_o}, exp_pins(4'h0, 3'b000));
    @(posedge sys_clk);
    for (int a = 0; a <= 8; a++) rd(4'(a), 8'h00);
    for (int a = 1; a < 8; a++) begin
      duty[0] = 8'($urandom);
      wr(4'(a), duty[0]);
      rd(4'(a), duty[0]);
    end
    wr(4'hF, 8'hA5);
    rd(4'hF, 8'h00);
    run_static();
    run_pwm(3'b010);
    run_pwm(3'b001);
    run_pwm(3'b011);
    for (int c = 0; c < 4; c++) wr(ADDR_DUTY0 + 4'(c), 8'hFF);
    wr(ADDR_STATE, 8'hFF);
    run_grp(3'b000, 8'($urandom), 8'h00);
    run_grp(3'b011, 8'hFF, 8'h00);
    run_grp(3'b100, 8'($urandom), 8'h00);
    run_grp(3'b101, 8'hFF, BLINK_FAST_MAX);
    run_grp(3'b110, 8'($urandom), BLINK_FAST_MAX + 8'h01);
    stop_test();
  end

  // Expected run is near 62k cycles
  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end
endmodule // tb
